// ===== asbp_pkg.sv
/*
 Shared constants for the addressed serial bus port.
 Assumes an 8-bit register port with a 16-bit address.
*/
package asbp_pkg;
	localparam logic [15:0] SER_MODE_ADDR = 16'hFF60;
	localparam logic [15:0] BUS_CTRL_ADDR = 16'hFF61;
	localparam logic [15:0] STATUS_ADDR = 16'hFF62;
	localparam logic [15:0] PORT_ADDR = 16'hFF63;
	localparam logic [15:0] SVA_ADDR = 16'hFF64;
	localparam logic [15:0] SHIFT_ADDR = 16'hFF65;
	localparam logic [7:0] SER_MODE_RST = 8'h00;
	localparam logic [7:0] BUS_CTRL_RST = 8'h00;
	localparam logic [7:0] PORT_RST = 8'h00;
	localparam logic [7:0] SVA_RST = 8'h00;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	// serial_mode_control fields
	localparam int EN_BIT = 7;
	localparam int COMPARE_BIT = 6;
	localparam int WAKE_BIT = 5;
	localparam int MODE_TOP_BIT = 4;
	localparam int MODE_MID_BIT = 3;
	localparam int CLK_HIGH_BIT = 2;
	localparam int CLK_LOW_BIT = 1;
	localparam int PIN_SEL_BIT = 0;
	// bus_control_reg fields
	localparam int RELEASE_TRIG_BIT = 0;
	localparam int COMMAND_TRIG_BIT = 1;
	localparam int RELEASE_DET_BIT = 2;
	localparam int COMMAND_DET_BIT = 3;
	localparam int BUSY_EN_BIT = 7;
	// status fields
	localparam int IRQ_FLAG_BIT = 0;
	localparam int BUSY_OUT_BIT = 1;
	localparam int ACTIVE_BIT = 2;
	// port register fields
	localparam int PIN_A_LATCH_BIT = 0;
	localparam int PIN_B_LATCH_BIT = 1;
	localparam int PIN_A_DIR_BIT = 2;
	localparam int PIN_B_DIR_BIT = 3;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

// ===== asbp_port.sv
/*
 Addressed serial bus port: mode register, shift register, serial clock,
 open-drain data pins and release/command detection.
 Assumes single-cycle register strobes and that pins are resolved outside.
*/
// Design decision made here: the address-and-strobe port.
//
// Notes on behaviour
// - Shift register advances on each serial clock rising edge.
// - Output latch drives selected data line, most significant bit first.
// - Data line level captured into shift register at clock rising edge.
// - Shift write starts transfer if enabled and clock idle or high.
// - Enabling the channel after the shift write starts nothing.
// - Wake-up addressing keeps data output released; else software loads FFH.
// - Write during slave busy is kept; starts once line returns high.
// - After eight bits the transfer stops and the irq flag sets.
// - Busy driven until next clock falling edge after release.
// - Data change while clock high is release or command.
// - First address after release compared with slave address.
// - Mode register at FF60H, reset 00H, enable/compare/wake/mode/clock.
// - Clock source: external, timer two, or timer clock select.
// - Mode bits pick 3-wire, addressed bus, or 2-wire with pin choice.
// - With wake-up, interrupt only on address match after release.
// - Compare flag is slave address equals shift register, 0 if disabled.
`timescale 1ns/1ps
module asbp_port (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// Internal clock sources
	input wire logic timer_two_tick_i,
	input wire logic timer_clock_tick_i,
	// Serial clock pin
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe_o,
	// Data lines
	input wire logic data_line_first_i,
	output logic data_line_first_o,
	output logic data_line_first_oe_o,
	input wire logic data_line_second_i,
	output logic data_line_second_o,
	output logic data_line_second_oe_o,
	// Interrupt request pulse
	output logic channel_irq_request_o
);
	logic [7:0] mode_q, busctl_q, port_q, sva_q, shift_q;
	logic [3:0] cnt_q;
	logic active_q, pending_q, irq_flag_q, busy_q, so_latch_q, sck_int_q;
	logic [2:0] sck_s_q, da_s_q, db_s_q;
	logic sck_f_q, da_f_q, db_f_q, sck_prev_q, line_prev_q;
	logic enable, wake, bus_mode, two_wire, internal_clk, tick;
	logic sck_eff, fall, rise, line_in, shift_wr, done, match;

	// Change counts once second and third stages agree
	function automatic logic filt(input logic [2:0] s, input logic f);
		filt = (s[1] == s[2]) ? s[2] : f;
	endfunction

	function automatic logic hit(input logic [15:0] a);
		hit = (addr_i == a);
	endfunction

	assign enable = mode_q[asbp_pkg::EN_BIT];
	assign wake = mode_q[asbp_pkg::WAKE_BIT];
	assign bus_mode = mode_q[asbp_pkg::MODE_TOP_BIT] &
		~mode_q[asbp_pkg::MODE_MID_BIT];
	assign two_wire = mode_q[asbp_pkg::MODE_TOP_BIT] &
		mode_q[asbp_pkg::MODE_MID_BIT];
	assign internal_clk = mode_q[asbp_pkg::CLK_LOW_BIT];
	assign tick = mode_q[asbp_pkg::CLK_HIGH_BIT] ? timer_clock_tick_i :
		timer_two_tick_i;
	assign sck_eff = internal_clk ? sck_int_q : sck_f_q;
	assign fall = sck_prev_q & ~sck_eff;
	assign rise = ~sck_prev_q & sck_eff;
	assign line_in = mode_q[asbp_pkg::PIN_SEL_BIT] ? da_f_q : db_f_q;
	assign shift_wr = wr_i & hit(asbp_pkg::SHIFT_ADDR);
	assign done = active_q & rise & (cnt_q == asbp_pkg::BITS_PER_BYTE - 4'h1);
	assign match = (sva_q == shift_q);

	// Pin synchronisers, three stages each
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sck_s_q <= 3'h7;
			da_s_q <= 3'h7;
			db_s_q <= 3'h7;
			sck_f_q <= 1'b1;
			da_f_q <= 1'b1;
			db_f_q <= 1'b1;
		end else begin
			sck_s_q <= {sck_s_q[1:0], serial_clock_pin_i};
			da_s_q <= {da_s_q[1:0], data_line_first_i};
			db_s_q <= {db_s_q[1:0], data_line_second_i};
			sck_f_q <= filt(sck_s_q, sck_f_q);
			da_f_q <= filt(da_s_q, da_f_q);
			db_f_q <= filt(db_s_q, db_f_q);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sck_prev_q <= 1'b1;
			line_prev_q <= 1'b1;
		end else begin
			sck_prev_q <= sck_eff;
			line_prev_q <= line_in;
		end
	end

	// Mode register; compare bit is never stored
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_q <= asbp_pkg::SER_MODE_RST;
		end else if (wr_i && hit(asbp_pkg::SER_MODE_ADDR)) begin
			mode_q <= wdata_i & ~(8'h01 << asbp_pkg::COMPARE_BIT);
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sva_q <= asbp_pkg::SVA_RST;
			port_q <= asbp_pkg::PORT_RST;
		end else if (wr_i) begin
			if (hit(asbp_pkg::SVA_ADDR)) begin
				sva_q <= wdata_i;
			end
			if (hit(asbp_pkg::PORT_ADDR)) begin
				port_q <= wdata_i;
			end
		end
	end

	// Pending start: only taken if enabled at write time
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pending_q <= 1'b0;
		end else if (!enable) begin
			pending_q <= 1'b0;
		end else if (shift_wr && !active_q) begin
			pending_q <= 1'b1;
		end else if (pending_q && !active_q && sck_eff &&
			(line_in || !internal_clk)) begin
			pending_q <= 1'b0;
		end
	end

	// Transfer state and bit counter
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			active_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (!enable || done) begin
			active_q <= 1'b0;
			cnt_q <= 4'h0;
		end else if (pending_q && !active_q && sck_eff &&
			(line_in || !internal_clk)) begin
			active_q <= 1'b1;
			cnt_q <= 4'h0;
		end else if (active_q && rise) begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// Internal clock: idles high, eight low pulses per byte
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sck_int_q <= 1'b1;
		end else if (!active_q || done) begin
			sck_int_q <= 1'b1;
		end else if (tick) begin
			sck_int_q <= ~sck_int_q;
		end
	end

	// Shift register: capture on rise; write loads when idle
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			shift_q <= asbp_pkg::SHIFT_RST;
		end else if (shift_wr && !active_q) begin
			shift_q <= wdata_i;
		end else if (active_q && rise) begin
			shift_q <= {shift_q[6:0], line_in};
		end
	end

	// Output latch: MSB first, advanced on falling edge
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			so_latch_q <= 1'b1;
		end else if (!active_q && pending_q && sck_eff) begin
			so_latch_q <= shift_q[7];
		end else if (active_q && fall) begin
			so_latch_q <= shift_q[7];
		end else if (wr_i && hit(asbp_pkg::BUS_CTRL_ADDR) && enable) begin
			if (wdata_i[asbp_pkg::RELEASE_TRIG_BIT]) begin
				so_latch_q <= 1'b1;
			end else if (wdata_i[asbp_pkg::COMMAND_TRIG_BIT]) begin
				so_latch_q <= 1'b0;
			end
		end
	end

	// Bus control: triggers self-clear, detections set over clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			busctl_q <= asbp_pkg::BUS_CTRL_RST;
		end else begin
			if (wr_i && hit(asbp_pkg::BUS_CTRL_ADDR)) begin
				busctl_q <= wdata_i & 8'hF0 | busctl_q & 8'h0C & wdata_i;
			end else begin
				busctl_q[1:0] <= 2'h0;
			end
			if (!enable) begin
				busctl_q[3:0] <= 4'h0;
			end else if (sck_eff && !active_q && line_in != line_prev_q) begin
				busctl_q[asbp_pkg::RELEASE_DET_BIT] <= line_in;
				busctl_q[asbp_pkg::COMMAND_DET_BIT] <= ~line_in;
			end else if (done && wake && bus_mode && !match) begin
				busctl_q[asbp_pkg::RELEASE_DET_BIT] <= 1'b0;
			end
		end
	end

	// Irq flag: set wins over write-one clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			irq_flag_q <= 1'b0;
			channel_irq_request_o <= 1'b0;
		end else begin
			channel_irq_request_o <= 1'b0;
			if (done && (!wake || (busctl_q[asbp_pkg::RELEASE_DET_BIT]
				&& match))) begin
				irq_flag_q <= 1'b1;
				channel_irq_request_o <= 1'b1;
			end else if (wr_i && hit(asbp_pkg::STATUS_ADDR) &&
				wdata_i[asbp_pkg::IRQ_FLAG_BIT]) begin
				irq_flag_q <= 1'b0;
			end
		end
	end

	// Busy holds until the falling edge after release
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			busy_q <= 1'b0;
		end else if (!enable) begin
			busy_q <= 1'b0;
		end else if (done && busctl_q[asbp_pkg::BUSY_EN_BIT]) begin
			busy_q <= 1'b1;
		end else if (fall && !busctl_q[asbp_pkg::BUSY_EN_BIT]) begin
			busy_q <= 1'b0;
		end
	end

	// Pin drivers; data-line low level comes only from the open-drain enable
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			data_line_first_o <= 1'b0;
			data_line_second_o <= 1'b0;
			data_line_first_oe_o <= 1'b0;
			data_line_second_oe_o <= 1'b0;
			serial_clock_pin_o <= 1'b1;
			serial_clock_pin_oe_o <= 1'b0;
		end else begin
			data_line_first_o <= 1'b0;
			data_line_second_o <= 1'b0;
			data_line_first_oe_o <= port_q[asbp_pkg::PIN_A_DIR_BIT] &
				~port_q[asbp_pkg::PIN_A_LATCH_BIT] & enable &
				(bus_mode | two_wire) & mode_q[asbp_pkg::PIN_SEL_BIT] &
				((~so_latch_q & ~wake) | busy_q);
			data_line_second_oe_o <= port_q[asbp_pkg::PIN_B_DIR_BIT] &
				~port_q[asbp_pkg::PIN_B_LATCH_BIT] & enable &
				(bus_mode | two_wire) & ~mode_q[asbp_pkg::PIN_SEL_BIT] &
				((~so_latch_q & ~wake) | busy_q);
			// Master clock is push-pull in bus mode, open-drain in 2-wire
			serial_clock_pin_o <= two_wire ? 1'b0 : sck_int_q;
			serial_clock_pin_oe_o <= enable & internal_clk &
				(bus_mode | (two_wire & ~sck_int_q));
		end
	end

	// Read data in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
			asbp_pkg::SER_MODE_ADDR: begin
				rdata_o <= {mode_q[7], enable & match, mode_q[5:0]};
			end
			asbp_pkg::BUS_CTRL_ADDR: begin
				rdata_o <= busctl_q;
			end
			asbp_pkg::STATUS_ADDR: begin
				rdata_o <= {5'h00, active_q, busy_q, irq_flag_q};
			end
			asbp_pkg::PORT_ADDR: begin
				rdata_o <= {2'h0, db_f_q, da_f_q, port_q[3:0]};
			end
			asbp_pkg::SVA_ADDR: begin
				rdata_o <= sva_q;
			end
			asbp_pkg::SHIFT_ADDR: begin
				rdata_o <= shift_q;
			end
			default: begin
				rdata_o <= 8'h00;
			end
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule

// ===== asbp_port_monitor.sv
/*
 Checker for the serial bus port: register reads and pin behaviour.
 Assumes it is bound to asbp_port and sees only that module's ports.
*/
`timescale 1ns/1ps
module asbp_port_monitor (
	// Clock, reset and register port
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	// Pins and interrupt
	input wire logic serial_clock_pin_i,
	input wire logic serial_clock_pin_oe_o,
	input wire logic data_line_first_oe_o,
	input wire logic channel_irq_request_o
);
	logic [7:0] mode_q;
	logic busy_q;
	logic sck_q;
	logic [3:0] rises_q;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	// Busy shadow is sticky, since the real release waits on a clock edge
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mode_q <= 8'h00;
			busy_q <= 1'b0;
		end else if (wr_i && addr_i == asbp_pkg::SER_MODE_ADDR) begin
			mode_q <= wdata_i;
		end else if (wr_i && addr_i == asbp_pkg::BUS_CTRL_ADDR) begin
			busy_q <= busy_q || wdata_i[asbp_pkg::BUSY_EN_BIT];
		end
	end
	// Raw clock rises since the last shift write
	always_ff @(posedge clk_i) begin
		sck_q <= serial_clock_pin_i;
		if (sys_rst_i || (wr_i && addr_i == asbp_pkg::SHIFT_ADDR)) begin
			rises_q <= 4'h0;
		end else if (serial_clock_pin_i && !sck_q && rises_q != 4'hF) begin
			rises_q <= rises_q + 4'h1;
		end
	end
	property p_reset_quiet;
		disable iff (1'b0)
		sys_rst_i |=> rdata_o == 8'h00 && !channel_irq_request_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("reset out");
	property p_unmapped;
		rd_i && (addr_i < 16'hFF60 || addr_i > 16'hFF65) |=>
			rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read");
	property p_readback;
		rd_i && addr_i == asbp_pkg::SER_MODE_ADDR |=>
			rdata_o[7] == mode_q[7] && rdata_o[5:0] == mode_q[5:0];
	endproperty
	a_readback: assert property (p_readback)
		else $error("mode readback");
	property p_compare_off;
		rd_i && addr_i == asbp_pkg::SER_MODE_ADDR && !mode_q[7] |=>
			!rdata_o[6];
	endproperty
	a_compare_off: assert property (p_compare_off)
		else $error("compare on");
	property p_wake;
		mode_q[5] && !busy_q |=> !data_line_first_oe_o;
	endproperty
	a_wake: assert property (p_wake)
		else $error("line pulled in wake");
	property p_irq_pulse;
		channel_irq_request_o |=> !channel_irq_request_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("irq too long");
	property p_irq_eight;
		channel_irq_request_o && !mode_q[1] |-> rises_q == 4'h8;
	endproperty
	a_irq_eight: assert property (p_irq_eight)
		else $error("irq not at 8");
	property p_ext_clock;
		!mode_q[1] |=> !serial_clock_pin_oe_o;
	endproperty
	a_ext_clock: assert property (p_ext_clock)
		else $error("clock driven");
endmodule
bind asbp_port asbp_port_monitor mon_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .serial_clock_pin_i(serial_clock_pin_i),
	.serial_clock_pin_oe_o(serial_clock_pin_oe_o),
	.data_line_first_oe_o(data_line_first_oe_o),
	.channel_irq_request_o(channel_irq_request_o));

// ===== asbp_master_model.sv
/*
 Far-side bus master: drives the serial clock and pulls the data line.
 Assumes the bench resolves the open-drain wire with a pull-up.
*/
`timescale 1ns/1ps
module asbp_master_model (
	// Pins
	input wire logic line_i,
	output logic sck_o,
	output logic pull_low_o
);
	// Clock stands high between frames
	initial begin
		sck_o = 1'b1;
		pull_low_o = 1'b0;
	end
	// Data bits move only while the clock is low; long low phase covers the
	// port's synchroniser and output register latency before each rise
	task automatic send_byte(input logic [7:0] tx, output logic [7:0] rx);
		#5;
		for (int i = 7; i >= 0; i--) begin
			sck_o = 1'b0;
			#50;
			pull_low_o = !tx[i];
			#100;
			sck_o = 1'b1;
			rx[i] = line_i;
			#50;
		end
		// Letting go with the clock high is a bus release condition
		pull_low_o = 1'b0;
	endtask
endmodule

// ===== asbp_port_test.sv
/*
 Self-checking bench for asbp_port with a far-side bus master.
 Assumes a pull-up on both data lines and a 40 MHz system clock.
*/
`timescale 1ns/1ps
module asbp_port_test;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic sck_o, sck_oe, d1_o, d1_oe, d2_o, d2_oe, irq, m_sck, m_pull;
	int num_errors = 0;
	int checks_done = 0;
	int irqs = 0;
	int cycles = 0;
	logic [2:0] tick_cnt = 3'h0;
	wire sck_w = sck_oe ? sck_o : m_sck;
	wire d1_w = !(d1_oe || m_pull);
	wire d2_w = !d2_oe;
	initial begin
		forever #12.5 clk_i = !clk_i;
	end
	asbp_port dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.timer_two_tick_i(tick_cnt[1:0] == 2'h0),
		.timer_clock_tick_i(tick_cnt == 3'h0),
		.serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
		.serial_clock_pin_oe_o(sck_oe), .data_line_first_i(d1_w),
		.data_line_first_o(d1_o), .data_line_first_oe_o(d1_oe),
		.data_line_second_i(d2_w), .data_line_second_o(d2_o),
		.data_line_second_oe_o(d2_oe), .channel_irq_request_o(irq));
	asbp_master_model master_u (.line_i(d1_w), .sck_o(m_sck),
		.pull_low_o(m_pull));
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		tick_cnt <= tick_cnt + 3'h1;
		if (irq === 1'b1) begin
			irqs <= irqs + 1;
		end
		if (cycles == 5000) begin
			num_errors = num_errors + 1;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] exp,
		input string what);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(what, rdata_o, exp);
	endtask
	// Fixed settle time covers the pin synchronisers and the irq pulse
	task automatic xfer(input logic [7:0] tx, input logic [7:0] exp,
		input int n);
		logic [7:0] rx;
		master_u.send_byte(tx, rx);
		repeat (12) @(posedge clk_i);
		chk("wire byte", rx, exp);
		chk("irq count", 8'(irqs), 8'(n));
	endtask
	task automatic t_regs;
		rchk(asbp_pkg::SER_MODE_ADDR, 8'h00, "mode reset");
		rchk(16'hFF70, 8'h00, "unmapped");
		wr(asbp_pkg::SER_MODE_ADDR, 8'hBF);
		rchk(asbp_pkg::SER_MODE_ADDR, 8'hFF, "compare on");
		wr(asbp_pkg::SER_MODE_ADDR, 8'h7F);
		rchk(asbp_pkg::SER_MODE_ADDR, 8'h3F, "compare ro");
	endtask
	task automatic t_xfer;
		wr(asbp_pkg::SER_MODE_ADDR, 8'h91);
		wr(asbp_pkg::PORT_ADDR, 8'h0F);
		wr(asbp_pkg::BUS_CTRL_ADDR, 8'h01);
		wr(asbp_pkg::PORT_ADDR, 8'h0C);
		wr(asbp_pkg::SHIFT_ADDR, 8'hA5);
		xfer(8'h3C, 8'h24, 1);
		rchk(asbp_pkg::SHIFT_ADDR, 8'h24, "rx byte");
		rchk(asbp_pkg::STATUS_ADDR, 8'h01, "status");
	endtask
	task automatic t_late;
		wr(asbp_pkg::STATUS_ADDR, 8'h01);
		wr(asbp_pkg::SER_MODE_ADDR, 8'h11);
		wr(asbp_pkg::SHIFT_ADDR, 8'h5A);
		wr(asbp_pkg::SER_MODE_ADDR, 8'h91);
		xfer(8'hFF, 8'hFF, 1);
		rchk(asbp_pkg::STATUS_ADDR, 8'h00, "no start");
	endtask
	task automatic t_wake;
		wr(asbp_pkg::PORT_ADDR, 8'h08);
		rchk(asbp_pkg::PORT_ADDR, 8'h38, "line ready");
		wr(asbp_pkg::PORT_ADDR, 8'h0C);
		wr(asbp_pkg::SER_MODE_ADDR, 8'hB1);
		wr(asbp_pkg::SHIFT_ADDR, 8'h00);
		xfer(8'h3C, 8'h3C, 1);
	endtask
	// Own clock from timer two; the slower source would miss the deadline
	task automatic t_clock;
		wr(asbp_pkg::SER_MODE_ADDR, 8'h92);
		wr(asbp_pkg::SHIFT_ADDR, 8'hFF);
		@(negedge clk_i);
		chk("clock drive", {7'h00, sck_oe}, 8'h01);
		chk("pin drive", {6'h00, d1_o, d2_o}, 8'h00);
		repeat (90) @(posedge clk_i);
		chk("irq count", 8'(irqs), 8'h02);
		rchk(asbp_pkg::SHIFT_ADDR, 8'hFF, "own clock byte");
		rchk(asbp_pkg::STATUS_ADDR, 8'h01, "own clock done");
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_regs();
		t_xfer();
		t_late();
		t_wake();
		t_clock();
		end_of_test();
	end
endmodule
